// File: pin_sync.v
// Purpose: Two-flop synchroniser with edge detection for one pin.
// Assumes: Pin is asynchronous to clk_sys.
// Notes: Edges are taken between the second and third flops only.
`timescale 1ns/1ps
module pin_sync #(
   parameter INIT = 1'b0
) (
   input wire clk_sys,
   input wire rst,
   input wire pin,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta; // First stage, read only by the second
   reg sync; // Safe copy of the pin
   reg last; // Previous safe value, for edges

   // Resynchronise and delay once for edge finding
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta <= INIT;
         sync <= INIT;
         last <= INIT;
      end else begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   assign level = sync;
   assign rise = sync & ~last;
   assign fall = ~sync & last;
endmodule // pin_sync

// File: window_limit_checker_assertions.sv
// Purpose: Port-level checks of the watchdog scan sequencer.
// Assumes: Sees only the sequencer's ports; one clock domain.
// Notes: Pins pass a synchroniser, so select reactions get a window.
`timescale 1ns/1ps
module window_limit_checker (
   input wire clk_sys,
   input wire rst,
   input wire cs_n,
   input wire eight_chan,
   input wire serial_out_oe,
   input wire int_n,
   input wire low_cross_flag_n,
   input wire high_cross_flag_n,
   input wire [3:0] cmp_tag,
   input wire cmp_diff,
   input wire cmp_busy
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic [8:0] slot_len; // Busy cycles spent on the current tag
   logic [3:0] last_tag; // Tag seen on the previous edge

   // Slot length counter; a new tag restarts it
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         slot_len <= 9'h000;
         last_tag <= 4'h0;
      end else begin
         last_tag <= cmp_tag;
         if (!cmp_busy) begin
            slot_len <= 9'h000; // Idle between slots
         end else if (cmp_tag != last_tag) begin
            slot_len <= 9'h001;
         end else begin
            slot_len <= slot_len + 9'h001;
         end
      end
   end

   int_release_a: assert property ($fell(cs_n) && !int_n |-> ##[2:6] int_n)
      else $error("interrupt not released after select fell");
   int_hold_a: assert property (cs_n && !int_n |=> !int_n)
      else $error("interrupt released while select high");
   flags_hold_a: assert property (cs_n && !int_n |=>
      $stable({low_cross_flag_n, high_cross_flag_n}))
      else $error("direction flags moved during alert");
   flags_need_int_a: assert property (
      !(low_cross_flag_n && high_cross_flag_n) |-> !int_n)
      else $error("direction flag low without interrupt");
   large_flags_a: assert property (eight_chan |->
      low_cross_flag_n && high_cross_flag_n)
      else $error("direction flag low on eight channel variant");
   busy_no_alert_a: assert property (cmp_busy |-> int_n && !serial_out_oe)
      else $error("alert or output active during a comparison");
   alert_idle_a: assert property ($fell(int_n) |-> cs_n && !cmp_busy)
      else $error("interrupt fell while still comparing");
   slot_len_a: assert property (cmp_busy |-> slot_len < 9'h0FA)
      else $error("comparison slot longer than two microseconds");
   oe_start_a: assert property ($rose(serial_out_oe) |-> !cs_n && int_n)
      else $error("output driven before select fell and alert cleared");
   // A slot that ends with select high ran its full 250 cycles
   slot_exact_a: assert property ($fell(cmp_busy) && cs_n |->
      $past(slot_len) == 9'h0F9)
      else $error("comparison slot not two microseconds long");
   diff_even_a: assert property (cmp_busy && cmp_diff |-> !cmp_tag[1])
      else $error("differential compare on the odd channel limits");

   // Main scenarios reached
   cover property ($fell(int_n));
   cover property ($rose(serial_out_oe));
   cover property (cmp_busy && cmp_diff);
   cover property (!low_cross_flag_n && !high_cross_flag_n);
endmodule // window_limit_checker

bind window_limit_watchdog window_limit_checker chk (
   .clk_sys(clk_sys),
   .rst(rst),
   .cs_n(cs_n),
   .eight_chan(eight_chan),
   .serial_out_oe(serial_out_oe),
   .int_n(int_n),
   .low_cross_flag_n(low_cross_flag_n),
   .high_cross_flag_n(high_cross_flag_n),
   .cmp_tag(cmp_tag),
   .cmp_diff(cmp_diff),
   .cmp_busy(cmp_busy)
);

// File: window_limit_host.sv
// Purpose: Host model owning the select-framed serial link.
// Assumes: Link clock period 80 ns, parked low outside frames.
// Notes: Input data is launched while the clock is low, read on its rise; results are read on its fall.
`timescale 1ns/1ps
module window_limit_host (
   output logic cs_n,
   output logic sclk,
   output logic serial_in,
   input wire serial_out
);
   // Idle link: deselected, clock standing still
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end

   // Shift a 16-bit word in MSB first, then deselect
   task automatic send(input logic [15:0] w);
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serial_in = w[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      cs_n = 1'b1;
      serial_in = ~serial_in; // Released line must not look held
   endtask

   // Select, then clock n result bits out, sampled on the fall
   task automatic fetch(input int n, output logic [32:0] w);
      w = 33'h0_0000_0000;
      cs_n = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
         w = {w[31:0], serial_out};
      end
      cs_n = 1'b1;
   endtask
endmodule // window_limit_host

// File: window_limit_watchdog.v
// Purpose: Watchdog scan sequencer of a 2/8 channel monitoring device.
// Assumes: cs_n, sclk, serial_in, conversion_timebase and compare inputs
//   are asynchronous pins; the limit memory sits outside and is
//   addressed by cmp_tag.
// Notes: eight_chan selects the 8-channel variant when high.
//
// Functional notes
// - Config word enters MSB first, 3-bit pair groups
// - Differential pair uses lower channel's limits
// - Sample serial input on rising clocks after select
// - Shorter select high accepts a new word
// - No crossing: interrupt and flags high, output off
// - Crossing drives interrupt and direction flags low; the eight-channel variant keeps the flags high
// - Alert outputs held until select falls
// - Result bits shift out on serial clock rises
// - Lower then upper limit, channels ascending
// - Crossed unless input strictly beyond limit
// - Inverted window needs no special handling
// - Tag is twice channel plus upper bit
// - Each comparison lasts two microseconds
// - First crossing sets status top and tag
// - Status width 4 or 16, top marks first
// - One more pass records remaining crossings
// - Tag written only at first crossing
// - After follow-up pass stop and raise alert
// - Shift out tag, config, power flag, status
// - Output order tag, config, power, status MSB-first
// - Disabled channels never cause an interrupt; a differential pair scans its lower channel's limits regardless of enable bits
// - Status fills downward, wrapping from first failure
// - Last twelve input bits are channel config
`timescale 1ns/1ps
`include "window_limit_watchdog_defines.vh"
module window_limit_watchdog (
   input wire clk_sys,
   input wire rst,
   input wire cs_n,
   input wire sclk,
   input wire serial_in,
   input wire conversion_timebase,
   input wire input_above,
   input wire input_below,
   input wire power_lost,
   input wire eight_chan,
   output reg serial_out,
   output reg serial_out_oe,
   output reg int_n,
   output reg low_cross_flag_n,
   output reg high_cross_flag_n,
   output reg [3:0] cmp_tag,
   output reg cmp_diff,
   output reg cmp_busy
);
   // Scan states
   localparam ST_IDLE = 3'h0;  // Receiving words, not watching
   localparam ST_ARM = 3'h1;   // Select high, waiting out hold time
   localparam ST_SCAN = 3'h2;  // Looking for the first crossing
   localparam ST_PASS = 3'h3;  // Follow-up pass after first crossing
   localparam ST_ALERT = 3'h4; // Stopped, alert shown
   localparam ST_SHIFT = 3'h5; // Shifting the result word out

   localparam [7:0] CMP_LAST = `CMP_LAST_CYCLE;

   // Synchronised pins
   wire cs_lvl;
   wire cs_rise;
   wire cs_fall;
   wire sclk_rise;
   wire din;
   wire osc_rise;
   wire above;
   wire below;
   wire pwr_lost;
   wire eight;

   reg [2:0] state; // Sequencer state
   reg [15:0] in_word; // Serial input shift register
   reg [5:0] in_cnt; // Bits received since select fell
   reg [11:0] cfg; // Programmed channel configuration
   reg [5:0] osc_cnt; // Timebase periods seen with select high
   reg [3:0] tag; // Limit under test
   reg [3:0] first_tag; // Tag register, first failed limit
   reg [3:0] pass_cnt; // Limits checked since the first failure
   reg [15:0] status; // Status word, top bit is the first failure
   reg lo_seen; // A lower limit was crossed
   reg hi_seen; // An upper limit was crossed
   reg slot_run; // A comparison slot is running
   reg [7:0] slot_cnt; // Cycles left in the slot
   reg pflag; // Power-fail bit
   reg [`OUT_BITS-1:0] out_sr; // Output shift register

   // Whether a limit takes part in the scan, from its pair group
   function lim_active;
      input [11:0] c;
      input [3:0] t;
      reg [2:0] g;
      begin
         case (t[3:2])
            2'h0: g = c[`GRP0_LSB +: 3];
            2'h1: g = c[`GRP1_LSB +: 3];
            2'h2: g = c[`GRP2_LSB +: 3];
            default: g = c[`GRP3_LSB +: 3];
         endcase
         if (g[`GRP_DIFF])
            lim_active = ~t[1];
         else if (t[1])
            lim_active = g[`GRP_ODD];
         else
            lim_active = g[`GRP_EVEN];
      end
   endfunction

   // Next tag in scan order, wrapping at the variant's last limit
   function [3:0] next_tag;
      input [3:0] t;
      input big;
      begin
         if (big)
            next_tag = t + 4'h1;
         else
            next_tag = {2'b00, t[1:0] + 2'b01};
      end
   endfunction

   // Pair is configured differential
   function lim_diff;
      input [11:0] c;
      input [3:0] t;
      begin
         case (t[3:2])
            2'h0: lim_diff = c[`GRP0_LSB + `GRP_DIFF];
            2'h1: lim_diff = c[`GRP1_LSB + `GRP_DIFF];
            2'h2: lim_diff = c[`GRP2_LSB + `GRP_DIFF];
            default: lim_diff = c[`GRP3_LSB + `GRP_DIFF];
         endcase
      end
   endfunction

   pin_sync #(.INIT(1'b1)) u_cs (
      .clk_sys(clk_sys), .rst(rst), .pin(cs_n),
      .level(cs_lvl), .rise(cs_rise), .fall(cs_fall)
   );
   pin_sync #(.INIT(1'b0)) u_sclk (
      .clk_sys(clk_sys), .rst(rst), .pin(sclk),
      .level(), .rise(sclk_rise), .fall()
   );
   pin_sync #(.INIT(1'b0)) u_din (
      .clk_sys(clk_sys), .rst(rst), .pin(serial_in),
      .level(din), .rise(), .fall()
   );
   pin_sync #(.INIT(1'b0)) u_osc (
      .clk_sys(clk_sys), .rst(rst), .pin(conversion_timebase),
      .level(), .rise(osc_rise), .fall()
   );
   pin_sync #(.INIT(1'b0)) u_above (
      .clk_sys(clk_sys), .rst(rst), .pin(input_above),
      .level(above), .rise(), .fall()
   );
   pin_sync #(.INIT(1'b0)) u_below (
      .clk_sys(clk_sys), .rst(rst), .pin(input_below),
      .level(below), .rise(), .fall()
   );
   pin_sync #(.INIT(1'b0)) u_pwr (
      .clk_sys(clk_sys), .rst(rst), .pin(power_lost),
      .level(pwr_lost), .rise(), .fall()
   );
   pin_sync #(.INIT(1'b0)) u_var (
      .clk_sys(clk_sys), .rst(rst), .pin(eight_chan),
      .level(eight), .rise(), .fall()
   );

   // Slot bookkeeping shared by both scan states
   wire scanning = (state == ST_SCAN) || (state == ST_PASS);
   wire slot_end = slot_run && (slot_cnt == 8'h00);
   wire skip = scanning && !slot_run && !lim_active(cfg, tag);
   wire step = slot_end || skip;
   // Lower crossed unless input above it, upper unless below it
   wire hit = slot_end && (tag[0] ? !below : !above);
   wire lo_any = lo_seen | (hit & ~tag[0]);
   wire hi_any = hi_seen | (hit & tag[0]);
   wire [3:0] top = eight ? `TOP_LARGE : `TOP_SMALL;
   wire [5:0] hold = eight ? `HOLD_LARGE : `HOLD_SMALL;
   wire [3:0] stat_idx = top - pass_cnt;
   wire word_ok = (in_cnt == `IN_WORD_BITS) &&
      (in_word[`MODE_MSB:`MODE_LSB] == `MODE_WATCHDOG);

   // Serial input word capture, MSB first on rising serial clock
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         in_word <= 16'h0000;
         in_cnt <= 6'h00;
      end else if (cs_fall) begin
         in_cnt <= 6'h00; // New frame
      end else if (!cs_lvl && sclk_rise) begin
         in_word <= {in_word[14:0], din};
         if (in_cnt != 6'h3F)
            in_cnt <= in_cnt + 6'h01;
      end
   end

   // Power-fail bit: set by power-up or loss, cleared when a read frame ends
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         pflag <= 1'b1;
      else if (pwr_lost)
         pflag <= 1'b1; // Set wins over the read clear
      else if (state == ST_SHIFT && cs_rise)
         pflag <= 1'b0;
   end

   // Comparison slot timer; one slot per enabled limit
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         slot_run <= 1'b0;
         slot_cnt <= 8'h00;
         cmp_busy <= 1'b0;
         cmp_tag <= 4'h0;
         cmp_diff <= 1'b0;
      end else if (!scanning || cs_fall) begin
         slot_run <= 1'b0; // Scan stopped or aborted
         cmp_busy <= 1'b0;
      end else if (!slot_run) begin
         if (lim_active(cfg, tag)) begin
            slot_run <= 1'b1;
            slot_cnt <= CMP_LAST;
            cmp_busy <= 1'b1;
            cmp_tag <= tag; // Limit memory address
            cmp_diff <= lim_diff(cfg, tag);
         end
      end else if (slot_cnt != 8'h00) begin
         slot_cnt <= slot_cnt - 8'h01;
      end else begin
         slot_run <= 1'b0; // Result taken this cycle
         cmp_busy <= 1'b0;
      end
   end

   // Main sequencer: arm, scan, follow-up pass, alert and read-out
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         cfg <= 12'h000;
         osc_cnt <= 6'h00;
         tag <= 4'h0;
         first_tag <= 4'h0;
         pass_cnt <= 4'h0;
         status <= 16'h0000;
         lo_seen <= 1'b0;
         hi_seen <= 1'b0;
         int_n <= 1'b1;
         low_cross_flag_n <= 1'b1;
         high_cross_flag_n <= 1'b1;
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
         out_sr <= {`OUT_BITS{1'b0}};
      end else begin
         case (state)
            ST_IDLE: begin
               serial_out_oe <= 1'b0;
               if (cs_rise && word_ok) begin
                  cfg <= in_word[`CFG_MSB:0];
                  osc_cnt <= 6'h00;
                  state <= ST_ARM;
               end
            end
            ST_ARM: begin
               if (cs_fall) begin
                  state <= ST_IDLE;
               end else if (osc_cnt == hold) begin
                  tag <= 4'h0;
                  status <= 16'h0000;
                  lo_seen <= 1'b0;
                  hi_seen <= 1'b0;
                  state <= ST_SCAN;
               end else if (osc_rise) begin
                  osc_cnt <= osc_cnt + 6'h01;
               end
            end
            ST_SCAN: begin
               if (cs_fall) begin
                  state <= ST_IDLE; // New word replaces watching
               end else if (step) begin
                  tag <= next_tag(tag, eight);
                  if (hit) begin
                     first_tag <= tag;
                     // Top bit marks the first failure
                     status <= eight ? `STATUS_TOP_LARGE :
                        `STATUS_TOP_SMALL;
                     lo_seen <= lo_any;
                     hi_seen <= hi_any;
                     pass_cnt <= 4'h1;
                     state <= ST_PASS;
                  end
               end
            end
            ST_PASS: begin
               if (cs_fall) begin
                  state <= ST_IDLE;
               end else if (step) begin
                  tag <= next_tag(tag, eight);
                  if (hit)
                     status[stat_idx] <= 1'b1;
                  lo_seen <= lo_any;
                  hi_seen <= hi_any;
                  if (pass_cnt == top) begin
                     int_n <= 1'b0;
                     // Direction flags exist on the small variant only
                     low_cross_flag_n <= eight | ~lo_any;
                     high_cross_flag_n <= eight | ~hi_any;
                     state <= ST_ALERT;
                  end else begin
                     pass_cnt <= pass_cnt + 4'h1;
                  end
               end
            end
            ST_ALERT: begin
               if (cs_fall) begin
                  int_n <= 1'b1;
                  low_cross_flag_n <= 1'b1;
                  high_cross_flag_n <= 1'b1;
                  // Tag, config, power flag, status, MSB first
                  if (eight)
                     out_sr <= {first_tag, cfg, pflag, status};
                  else
                     out_sr <= {first_tag, cfg, pflag, status[3:0],
                        `OUT_PAD_SMALL};
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (cs_rise) begin
                  serial_out_oe <= 1'b0; // Frame over, release pin
                  serial_out <= 1'b0;
                  state <= ST_IDLE;
               end else if (sclk_rise) begin
                  serial_out <= out_sr[`OUT_BITS-1];
                  serial_out_oe <= 1'b1;
                  out_sr <= {out_sr[`OUT_BITS-2:0], 1'b0};
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // window_limit_watchdog

// File: window_limit_watchdog_defines.vh
// Purpose: Shared constants for the window limit watchdog sequencer.
// Assumes: 125 MHz system clock; figures below are the block's own.
// Notes: Definitions only; included by bare name.
`ifndef WINDOW_LIMIT_WATCHDOG_DEFINES_VH
`define WINDOW_LIMIT_WATCHDOG_DEFINES_VH

// Serial input word: 4-bit mode field then 12 configuration bits
`define IN_WORD_BITS 6'h10
`define MODE_MSB 15
`define MODE_LSB 12
`define CFG_MSB 11
`define MODE_WATCHDOG 4'h8

// Three-bit group per channel pair: differential, odd enable, even enable
`define GRP_DIFF 2
`define GRP_ODD 1
`define GRP_EVEN 0

// Group of each pair inside the configuration word
`define GRP0_LSB 9
`define GRP1_LSB 6
`define GRP2_LSB 3
`define GRP3_LSB 0

// Limits per variant and highest tag / status index
`define TOP_SMALL 4'h3
`define TOP_LARGE 4'hF
`define STATUS_TOP_SMALL 16'h0008
`define STATUS_TOP_LARGE 16'h8000

// Chip-select high time, in conversion timebase periods, before scanning
`define HOLD_SMALL 6'h08
`define HOLD_LARGE 6'h20

// Output word: 4 tag + 12 cfg + 1 power flag + 4 or 16 status = 33 max
`define OUT_BITS 33
`define OUT_PAD_SMALL 12'h000

// One limit comparison: 2 us is 250 cycles of the 8 ns system clock;
// the slot counter loads the index of its last cycle
`define CMP_LAST_CYCLE 8'hF9

`endif

// File: window_limit_watchdog_tb_top.sv
// Purpose: Self-checking bench for the watchdog scan sequencer.
// Assumes: Host model owns the link; bench owns comparator and pins.
// Notes: Crossings are forced per limit through a mask on cmp_tag.
`timescale 1ns/1ps
`include "window_limit_watchdog_defines.vh"
module window_limit_watchdog_tb_top;
   logic clk_sys = 1'b0; // 125 MHz system clock
   logic rst = 1'b1; // Held over the first two edges
   logic conversion_timebase = 1'b0; // Free running oscillator
   logic input_above = 1'b1; // Comparator outputs
   logic input_below = 1'b1;
   logic power_lost = 1'b0;
   logic eight_chan = 1'b0; // Variant select
   logic [15:0] fail_mask = 16'h0000; // Limits that read as crossed
   wire cs_n, sclk, serial_in, serial_out, serial_out_oe, int_n;
   wire low_cross_flag_n, high_cross_flag_n, cmp_diff, cmp_busy;
   wire [3:0] cmp_tag;
   int n_errors = 0;
   int n_tests = 0;

   always #4 clk_sys = ~clk_sys;
   // 200 ns oscillator, slow enough that hold counts show
   always #100 conversion_timebase = ~conversion_timebase;

   // Comparator: masked lower limits not above, upper not below
   always @(posedge clk_sys) begin
      input_above <= !(fail_mask[cmp_tag] && !cmp_tag[0]);
      input_below <= !(fail_mask[cmp_tag] && cmp_tag[0]);
   end

   window_limit_watchdog dut (.clk_sys(clk_sys), .rst(rst),
      .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
      .conversion_timebase(conversion_timebase),
      .input_above(input_above), .input_below(input_below),
      .power_lost(power_lost), .eight_chan(eight_chan),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .int_n(int_n), .low_cross_flag_n(low_cross_flag_n),
      .high_cross_flag_n(high_cross_flag_n), .cmp_tag(cmp_tag),
      .cmp_diff(cmp_diff), .cmp_busy(cmp_busy));
   window_limit_host host (.cs_n(cs_n), .sclk(sclk),
      .serial_in(serial_in), .serial_out(serial_out));

   // Compare and count
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Single exit point of the run
   task automatic complete_run;
      $display("Counts: tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Arm watching, await the alert, read and compare the result word
   task automatic watch(input string name, input logic big, pre,
         input logic [11:0] cfg, input logic [15:0] mask, late,
         input logic [6:0] flags, input logic [32:0] exp);
      logic [32:0] got;
      int k;
      @(posedge clk_sys);
      eight_chan <= big;
      fail_mask <= mask;
      // Late crossings appear once the scan reaches tag 3
      fork
         begin
            wait (cmp_busy && cmp_tag == 4'h3);
            @(posedge clk_sys);
            fail_mask <= fail_mask | late;
         end
      join_none
      // Leave select high for ten clocks after any earlier read frame
      #82;
      if (pre) begin
         host.send({`MODE_WATCHDOG, 12'h1FF}); // Superseded below
         #400;
      end
      host.send({`MODE_WATCHDOG, cfg});
      k = 0;
      // Select stays high while waiting, well past the hold count
      while (int_n !== 1'b0 && k < 12000) begin
         @(posedge clk_sys);
         k++;
      end
      check(int_n, 1'b0);
      check({low_cross_flag_n, high_cross_flag_n}, flags[6:5]);
      // Last limit compared and its pair mode stay on the memory port
      check({cmp_tag, cmp_diff}, flags[4:0]);
      @(posedge clk_sys);
      #2 host.fetch(big ? 33 : 21, got);
      check(got, exp);
      check({int_n, low_cross_flag_n, high_cross_flag_n}, 3'h7);
      $display("Test done: %s", name);
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check({int_n, low_cross_flag_n, high_cross_flag_n, serial_out_oe},
            4'hE);
      watch("two lower", 1'b0, 1'b0, 12'h6A5, 16'h0005, 16'h0000,
            {2'b01, 4'h3, 1'b0},
            {12'h000, 4'h0, 12'h6A5, 1'b1, 4'hA});
      watch("wrap both", 1'b0, 1'b1, 12'h7C3, 16'h0008, 16'h0001,
            {2'b00, 4'h2, 1'b0},
            {12'h000, 4'h3, 12'h7C3, 1'b0, 4'hC});
      power_lost <= 1'b1;
      repeat (3) @(posedge clk_sys);
      power_lost <= 1'b0;
      watch("eight diff", 1'b1, 1'b0, 12'h7D8, 16'h1260, 16'h0000,
            {2'b11, 4'h4, 1'b1},
            {4'h5, 12'h7D8, 1'b1, 16'h8800});
      // Unknown mode code is ignored: no scan, no alert
      @(posedge clk_sys);
      eight_chan <= 1'b0;
      fail_mask <= 16'hFFFF;
      #82 host.send({4'h9, 12'h600});
      repeat (3000) @(posedge clk_sys);
      check({int_n, cmp_busy}, 2'b10);
      $display("Test done: refused mode");
      complete_run();
   end

   // Watchdog: about three times the expected run length
   initial begin
      #300000;
      n_errors++;
      complete_run();
   end
endmodule // window_limit_watchdog_tb_top
